// ==== logic/trr_pkg.sv ====
// Constants for the telemetry readback register bank.
// Assumes a protocol engine on the same clock hands over decoded commands.
// Behaviour
// - Info register bit 5 is ECC status, one means clean; other bits zero.
// - ECC bit refreshed after restore, reset command, power-on and bulk read.
// - Info register is read-only and answers with two bytes.
// - Code 0x88 returns input voltage, unpaged, short float word.
// - Code 0x8B returns paged output voltage in unsigned fixed format.
// - Code 0x89 returns total input current, the sum of both channels.
// - Code 0xED returns paged input current, offset plus current times duty.
// - Code 0x8C returns paged average output current in amperes.
// - Code 0x8D returns paged external temperature used for compensation.
// - Code 0x8E returns unpaged die temperature affecting nothing else.
// - Code 0x94 returns paged top gate duty cycle in percent.
// - Code 0x95 returns unpaged switching frequency in kHz.
// - Code 0x96 returns paged output power from a correlated pair.
// - Hold peak output voltage 0xDD paged and input voltage 0xDE.
// - Hold peak output current 0xD7 and external temperature 0xDF per page.
// - Hold peak die temperature at unpaged code 0xF4.
// - Peaks cleared only by clear-peaks command; reads leave them alone.
// - Code 0xD8 is a read/write select byte, reset 0x00.
// - Code 0xDA flags each parameter converted in the short loop since last cleared.
// - Telemetry reads are read-only two-byte words in their formats.
// - Select 0x0D runs the short loop; 0x00 restores the full loop.
// - Reserved select monitors die temperature and raises invalid data.
// - Status bits 0 to 3 set on conversion, cleared by writing one; code sets them only while select is 0x0D.
package trr_pkg;
	localparam logic [7:0] CODE_VIN        = 8'h88;
	localparam logic [7:0] CODE_IIN_TOTAL  = 8'h89;
	localparam logic [7:0] CODE_VOUT       = 8'h8b;
	localparam logic [7:0] CODE_IOUT       = 8'h8c;
	localparam logic [7:0] CODE_TEMP_EXT   = 8'h8d;
	localparam logic [7:0] CODE_TEMP_DIE   = 8'h8e;
	localparam logic [7:0] CODE_DUTY       = 8'h94;
	localparam logic [7:0] CODE_FREQ       = 8'h95;
	localparam logic [7:0] CODE_POUT       = 8'h96;
	localparam logic [7:0] CODE_IOUT_PEAK  = 8'hd7;
	localparam logic [7:0] CODE_ADC_SEL    = 8'hd8;
	localparam logic [7:0] CODE_ADC_STATUS = 8'hda;
	localparam logic [7:0] CODE_VOUT_PEAK  = 8'hdd;
	localparam logic [7:0] CODE_VIN_PEAK   = 8'hde;
	localparam logic [7:0] CODE_TEXT_PEAK  = 8'hdf;
	localparam logic [7:0] CODE_IIN_CHAN   = 8'hed;
	localparam logic [7:0] CODE_TDIE_PEAK  = 8'hf4;
	localparam logic [7:0] CODE_INFO       = 8'hb6;

	// Select values, also used to name conversion results
	localparam logic [7:0] SEL_FULL_LOOP   = 8'h00;
	localparam logic [7:0] SEL_VIN         = 8'h01;
	localparam logic [7:0] SEL_DIE_TEMP    = 8'h04;
	localparam logic [7:0] SEL_VOUT0       = 8'h05;
	localparam logic [7:0] SEL_IOUT0       = 8'h06;
	localparam logic [7:0] SEL_TEMP0       = 8'h08;
	localparam logic [7:0] SEL_VOUT1       = 8'h09;
	localparam logic [7:0] SEL_IOUT1       = 8'h0a;
	localparam logic [7:0] SEL_TEMP1       = 8'h0c;
	localparam logic [7:0] SEL_SHORT_LOOP  = 8'h0d;

	localparam logic [7:0] ADC_SEL_RESET   = 8'h00;
	localparam int         INFO_ECC_BIT    = 5;
	localparam int         STATUS_BITS     = 4;
	localparam logic [1:0] BYTES_NONE      = 2'h0;
	localparam logic [1:0] BYTES_ONE       = 2'h1;
	localparam logic [1:0] BYTES_TWO       = 2'h2;

	// Slots of measured values that also have a peak
	typedef enum logic [2:0] {
		SLOT_VIN   = 3'h0,
		SLOT_DIE   = 3'h1,
		SLOT_VOUT0 = 3'h2,
		SLOT_VOUT1 = 3'h3,
		SLOT_IOUT0 = 3'h4,
		SLOT_IOUT1 = 3'h5,
		SLOT_TEMP0 = 3'h6,
		SLOT_TEMP1 = 3'h7
	} trr_slot_t;
	localparam int NUM_SLOTS = 8;
endpackage

// ==== logic/trr_regs.sv ====
// Telemetry readback register bank: readings, peaks, ADC select and status.
// Assumes the command engine, ADC and arithmetic unit share i_clock.
`timescale 1ns/1ps
module trr_regs #(
	parameter int DATA_W = 16
) (
	input  wire logic              i_clock,
	input  wire logic              i_rst,
	input  wire logic              i_page,
	input  wire logic              i_access,
	input  wire logic              i_write,
	input  wire logic [7:0]        i_code,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_conv_valid,
	input  wire logic [7:0]        i_conv_param,
	input  wire logic [DATA_W-1:0] i_conv_value,
	input  wire logic              i_calc_valid,
	input  wire logic [DATA_W-1:0] i_calc_iin_ch0,
	input  wire logic [DATA_W-1:0] i_calc_iin_ch1,
	input  wire logic [DATA_W-1:0] i_calc_iin_total,
	input  wire logic [DATA_W-1:0] i_calc_duty_ch0,
	input  wire logic [DATA_W-1:0] i_calc_duty_ch1,
	input  wire logic [DATA_W-1:0] i_calc_pout_ch0,
	input  wire logic [DATA_W-1:0] i_calc_pout_ch1,
	input  wire logic [DATA_W-1:0] i_calc_freq,
	input  wire logic              i_clear_peaks,
	input  wire logic              i_ecc_update,
	input  wire logic              i_ecc_clean,
	output logic [DATA_W-1:0]      o_rdata,
	output logic                   o_rvalid,
	output logic [1:0]             o_byte_count,
	output logic                   o_invalid_cmd,
	output logic                   o_invalid_data,
	output logic [7:0]             o_adc_select,
	output logic                   o_short_loop
);
	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Short float to a common fixed scale so peaks compare by true value
	function automatic logic signed [47:0] l11_scale(input logic [15:0] v);
		logic signed [47:0] m;
		logic        [4:0]  sh;
		m  = {{37{v[10]}}, v[10:0]};
		sh = {~v[15], v[14:11]};
		return m <<< sh;
	endfunction

	function automatic logic sel_valid(input logic [7:0] s);
		unique case (s)
			trr_pkg::SEL_FULL_LOOP, trr_pkg::SEL_VIN, trr_pkg::SEL_DIE_TEMP,
			trr_pkg::SEL_VOUT0, trr_pkg::SEL_IOUT0, trr_pkg::SEL_TEMP0,
			trr_pkg::SEL_VOUT1, trr_pkg::SEL_IOUT1, trr_pkg::SEL_TEMP1,
			trr_pkg::SEL_SHORT_LOOP: sel_valid = 1'b1;
			default:                 sel_valid = 1'b0;
		endcase
	endfunction

	localparam logic [7:0] SLOT_PARAM [trr_pkg::NUM_SLOTS] = '{
		trr_pkg::SEL_VIN, trr_pkg::SEL_DIE_TEMP, trr_pkg::SEL_VOUT0, trr_pkg::SEL_VOUT1,
		trr_pkg::SEL_IOUT0, trr_pkg::SEL_IOUT1, trr_pkg::SEL_TEMP0, trr_pkg::SEL_TEMP1};
	localparam logic SLOT_UNSIGNED [trr_pkg::NUM_SLOTS] = '{
		1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

	wire logic rd_req = i_access & ~i_write;
	wire logic wr_req = i_access & i_write;

	// ****************************************************************
	// Measured readings and peaks
	// ****************************************************************
	logic [DATA_W-1:0] reading_q [trr_pkg::NUM_SLOTS];
	logic [DATA_W-1:0] peak_q    [trr_pkg::NUM_SLOTS];
	logic              peak_ok_q [trr_pkg::NUM_SLOTS];

	genvar g;
	generate
		for (g = 0; g < trr_pkg::NUM_SLOTS; g++) begin : g_slot
			wire logic hit = i_conv_valid && (i_conv_param == SLOT_PARAM[g]);
			wire logic higher = SLOT_UNSIGNED[g] ? (i_conv_value > peak_q[g]) :
				(l11_scale(i_conv_value) > l11_scale(peak_q[g]));

			always_ff @(posedge i_clock or posedge i_rst) begin
				if (i_rst) begin
					reading_q[g] <= '0;
				end else if (hit) begin
					reading_q[g] <= i_conv_value;
				end
			end

			// Clear only by command; a result in the same cycle starts the new peak
			always_ff @(posedge i_clock or posedge i_rst) begin
				if (i_rst) begin
					peak_q[g]    <= '0;
					peak_ok_q[g] <= 1'b0;
				end else if (hit && (i_clear_peaks || !peak_ok_q[g] || higher)) begin
					peak_q[g]    <= i_conv_value;
					peak_ok_q[g] <= 1'b1;
				end else if (i_clear_peaks) begin
					peak_q[g]    <= '0;
					peak_ok_q[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Calculated values
	// ****************************************************************
	logic [DATA_W-1:0] iin_ch_q [2];
	logic [DATA_W-1:0] duty_q   [2];
	logic [DATA_W-1:0] pout_q   [2];
	logic [DATA_W-1:0] iin_total_q;
	logic [DATA_W-1:0] freq_q;

	// Loaded as one set so power pairs with its own voltage and current
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			iin_ch_q[0] <= '0;
			iin_ch_q[1] <= '0;
			duty_q[0]   <= '0;
			duty_q[1]   <= '0;
			pout_q[0]   <= '0;
			pout_q[1]   <= '0;
			iin_total_q <= '0;
			freq_q      <= '0;
		end else if (i_calc_valid) begin
			iin_ch_q[0] <= i_calc_iin_ch0;
			iin_ch_q[1] <= i_calc_iin_ch1;
			iin_total_q <= i_calc_iin_total;
			duty_q[0]   <= i_calc_duty_ch0;
			duty_q[1]   <= i_calc_duty_ch1;
			pout_q[0]   <= i_calc_pout_ch0;
			pout_q[1]   <= i_calc_pout_ch1;
			freq_q      <= i_calc_freq;
		end
	end

	// ****************************************************************
	// ECC status
	// ****************************************************************
	logic ecc_q;
	logic ecc_por_q;

	// Power-on capture happens on the first edge after release
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ecc_q     <= 1'b0;
			ecc_por_q <= 1'b1;
		end else begin
			ecc_por_q <= 1'b0;
			if (ecc_por_q || i_ecc_update) begin
				ecc_q <= i_ecc_clean;
			end
		end
	end

	// ****************************************************************
	// ADC select and conversion status
	// ****************************************************************
	logic [7:0]                     adc_sel_q;
	logic [trr_pkg::STATUS_BITS-1:0] status_q;
	logic [trr_pkg::STATUS_BITS-1:0] status_set;
	logic [trr_pkg::STATUS_BITS-1:0] status_clr;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			adc_sel_q <= trr_pkg::ADC_SEL_RESET;
		end else if (wr_req && i_code == trr_pkg::CODE_ADC_SEL) begin
			adc_sel_q <= i_wdata[7:0];
		end
	end

	always_comb begin
		status_set = '0;
		if (i_conv_valid && adc_sel_q == trr_pkg::SEL_SHORT_LOOP) begin
			status_set[0] = (i_conv_param == trr_pkg::SEL_VOUT0);
			status_set[1] = (i_conv_param == trr_pkg::SEL_IOUT0);
			status_set[2] = (i_conv_param == trr_pkg::SEL_VOUT1);
			status_set[3] = (i_conv_param == trr_pkg::SEL_IOUT1);
		end
		status_clr = '0;
		if (wr_req && i_code == trr_pkg::CODE_ADC_STATUS) begin
			status_clr = i_wdata[trr_pkg::STATUS_BITS-1:0];
		end
	end

	// A conversion landing on the clearing write is kept
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			status_q <= '0;
		end else begin
			status_q <= (status_q & ~status_clr) | status_set;
		end
	end

	// Effective selection for the ADC sequencer
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_adc_select   <= trr_pkg::ADC_SEL_RESET;
			o_short_loop   <= 1'b0;
			o_invalid_data <= 1'b0;
		end else begin
			o_adc_select   <= sel_valid(adc_sel_q) ? adc_sel_q : trr_pkg::SEL_DIE_TEMP;
			o_short_loop   <= (adc_sel_q == trr_pkg::SEL_SHORT_LOOP);
			o_invalid_data <= ~sel_valid(adc_sel_q);
		end
	end

	// ****************************************************************
	// Read answer
	// ****************************************************************
	logic [DATA_W-1:0] rd_d;
	logic [1:0]        cnt_d;
	logic              ro_d;
	logic [2:0]        pg;

	always_comb begin
		pg    = {2'h0, i_page};
		rd_d  = '0;
		cnt_d = trr_pkg::BYTES_TWO;
		ro_d  = 1'b1;
		unique case (i_code)
			trr_pkg::CODE_VIN:        rd_d = reading_q[trr_pkg::SLOT_VIN];
			trr_pkg::CODE_VOUT:       rd_d = reading_q[3'(trr_pkg::SLOT_VOUT0 + pg)];
			trr_pkg::CODE_IIN_TOTAL:  rd_d = iin_total_q;
			trr_pkg::CODE_IIN_CHAN:   rd_d = iin_ch_q[i_page];
			trr_pkg::CODE_IOUT:       rd_d = reading_q[3'(trr_pkg::SLOT_IOUT0 + pg)];
			trr_pkg::CODE_TEMP_EXT:   rd_d = reading_q[3'(trr_pkg::SLOT_TEMP0 + pg)];
			trr_pkg::CODE_TEMP_DIE:   rd_d = reading_q[trr_pkg::SLOT_DIE];
			trr_pkg::CODE_DUTY:       rd_d = duty_q[i_page];
			trr_pkg::CODE_FREQ:       rd_d = freq_q;
			trr_pkg::CODE_POUT:       rd_d = pout_q[i_page];
			trr_pkg::CODE_VOUT_PEAK:  rd_d = peak_q[3'(trr_pkg::SLOT_VOUT0 + pg)];
			trr_pkg::CODE_VIN_PEAK:   rd_d = peak_q[trr_pkg::SLOT_VIN];
			trr_pkg::CODE_IOUT_PEAK:  rd_d = peak_q[3'(trr_pkg::SLOT_IOUT0 + pg)];
			trr_pkg::CODE_TEXT_PEAK:  rd_d = peak_q[3'(trr_pkg::SLOT_TEMP0 + pg)];
			trr_pkg::CODE_TDIE_PEAK:  rd_d = peak_q[trr_pkg::SLOT_DIE];
			trr_pkg::CODE_INFO: begin
				rd_d[trr_pkg::INFO_ECC_BIT] = ecc_q;
			end
			trr_pkg::CODE_ADC_SEL: begin
				rd_d  = {8'h00, adc_sel_q};
				cnt_d = trr_pkg::BYTES_ONE;
				ro_d  = 1'b0;
			end
			trr_pkg::CODE_ADC_STATUS: begin
				rd_d  = {12'h000, status_q};
				cnt_d = trr_pkg::BYTES_ONE;
				ro_d  = 1'b0;
			end
			default: begin
				// Codes owned by other blocks: no bytes, no fault here
				cnt_d = trr_pkg::BYTES_NONE;
				ro_d  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_rdata       <= '0;
			o_rvalid      <= 1'b0;
			o_byte_count  <= trr_pkg::BYTES_NONE;
			o_invalid_cmd <= 1'b0;
		end else begin
			o_rvalid      <= rd_req;
			o_invalid_cmd <= wr_req & ro_d;
			if (rd_req) begin
				o_rdata      <= rd_d;
				o_byte_count <= cnt_d;
			end
		end
	end
endmodule

// ==== bench/trr_regs_props.sv ====
// Port checker for trr_regs, bound to every instance.
// Assumes one clock domain and the async active-high reset.
`timescale 1ns/1ps
module trr_regs_props #(
	parameter int DATA_W = 16
) (
	input wire logic              i_clock,
	input wire logic              i_rst,
	input wire logic              i_access,
	input wire logic              i_write,
	input wire logic [7:0]        i_code,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic              i_clear_peaks,
	input wire logic [DATA_W-1:0] o_rdata,
	input wire logic              o_rvalid,
	input wire logic [1:0]        o_byte_count,
	input wire logic              o_invalid_cmd,
	input wire logic              o_invalid_data,
	input wire logic [7:0]        o_adc_select,
	input wire logic              o_short_loop
);
	// ********
	// Properties
	// ********
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	logic rd, wr, ro, sel;
	assign rd  = i_access && !i_write;
	assign wr  = i_access && i_write;
	assign sel = wr && i_code == 8'hd8;
	assign ro  = i_code inside {8'h88, 8'h89, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h94, 8'h95, 8'h96,
		8'hd7, 8'hdd, 8'hde, 8'hdf, 8'hed, 8'hf4, trr_pkg::CODE_INFO};
	property p_read_answer; rd |=> o_rvalid; endproperty
	property p_no_stray; !rd |=> !o_rvalid; endproperty
	property p_word_count; rd && ro |=> o_byte_count == 2'h2; endproperty
	property p_byte_count; rd && i_code inside {8'hd8, 8'hda} |=> o_byte_count == 2'h1; endproperty
	property p_ro_write; wr && ro |=> o_invalid_cmd; endproperty
	property p_no_invalid; !(wr && ro) |=> !o_invalid_cmd; endproperty
	property p_info_reserved;
		rd && i_code == trr_pkg::CODE_INFO |=> o_rdata[15:6] == 10'h000 && o_rdata[4:0] == 5'h00;
	endproperty
	property p_status_reserved; rd && i_code == 8'hda |=> o_rdata[15:4] == 12'h000; endproperty
	property p_short;
		sel && i_wdata[7:0] == 8'h0d ##1 !sel |=> o_short_loop && o_adc_select == 8'h0d;
	endproperty
	property p_full;
		sel && i_wdata[7:0] == 8'h00 ##1 !sel |=> !o_short_loop && o_adc_select == 8'h00;
	endproperty
	// Reserved select falls back to die temperature, flagged as a level
	property p_reserved;
		sel && (i_wdata[7:0] inside {8'h02, 8'h03, 8'h07, 8'h0b} || i_wdata[7:0] > 8'h0d) ##1 !sel
			|=> o_invalid_data && o_adc_select == 8'h04;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered");
	a_no_stray: assert property (p_no_stray) else $error("answer without read");
	a_word_count: assert property (p_word_count) else $error("word count wrong");
	a_byte_count: assert property (p_byte_count) else $error("byte count wrong");
	a_ro_write: assert property (p_ro_write) else $error("write not flagged");
	a_no_invalid: assert property (p_no_invalid) else $error("false flag");
	a_info_reserved: assert property (p_info_reserved) else $error("info bits");
	a_status_reserved: assert property (p_status_reserved) else $error("status bits");
	a_short: assert property (p_short) else $error("short loop not set");
	a_full: assert property (p_full) else $error("full loop not set");
	a_reserved: assert property (p_reserved) else $error("reserved select");
	c_short: cover property (sel && i_wdata[7:0] == 8'h0d);
	c_clear: cover property (i_clear_peaks);
	c_ro_write: cover property (wr && ro);
endmodule
bind trr_regs trr_regs_props #(.DATA_W(DATA_W)) i_trr_regs_props (.i_clock, .i_rst, .i_access,
	.i_write, .i_code, .i_wdata, .i_clear_peaks, .o_rdata, .o_rvalid, .o_byte_count,
	.o_invalid_cmd, .o_invalid_data, .o_adc_select, .o_short_loop);

// ==== bench/trr_host.sv ====
// Host model: issues one queued command per clock, idle entries stall.
// Assumes commands are queued between clock edges.
`timescale 1ns/1ps
module trr_host (
	input  wire logic   i_clock,
	output logic        o_access,
	output logic        o_write,
	output logic        o_page,
	output logic [7:0]  o_code,
	output logic [15:0] o_wdata
);
	// ********
	// Command queue
	// ********
	logic [26:0] q [$];
	logic [26:0] e;
	initial begin
		o_access = 1'b0;
		o_write = 1'b0;
		o_page = 1'b0;
		o_code = 8'h00;
		o_wdata = 16'h0000;
	end
	task automatic put(input logic idle, w, p, input logic [7:0] c, input logic [15:0] d);
		q.push_back({idle, w, p, c, d});
	endtask
	always @(posedge i_clock) begin
		if (q.size() > 0 && q[0][26] == 1'b0) begin
			e = q.pop_front();
			o_access <= 1'b1;
			o_write <= e[25];
			o_page <= e[24];
			o_code <= e[23:16];
			o_wdata <= e[15:0];
		end else begin
			if (q.size() > 0) void'(q.pop_front());
			// Released code and data lines toggle so stale values never look valid
			o_access <= 1'b0;
			o_code <= ~o_code;
			o_wdata <= ~o_wdata;
		end
	end
endmodule

// ==== bench/trr_regs_test.sv ====
// Bench for trr_regs: host model on the command port, bench on the rest.
// Assumes the package and the checker are compiled first.
`timescale 1ns/1ps
module trr_regs_test;
	// ********
	// Stimulus and checking
	// ********
	localparam logic [7:0] PRM [8] = '{8'h01, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h0c};
	localparam logic [7:0] RCD [8] = '{8'h88, 8'h8e, 8'h8b, 8'h8c, 8'h8d, 8'h8b, 8'h8c, 8'h8d};
	localparam logic [7:0] PCD [8] = '{8'hde, 8'hf4, 8'hdd, 8'hd7, 8'hdf, 8'hdd, 8'hd7, 8'hdf};
	localparam logic [7:0] CCD [8] = '{8'hed, 8'hed, 8'h89, 8'h94, 8'h94, 8'h96, 8'h96, 8'h95};
	localparam logic [7:0] PGS = 8'he0;
	localparam logic [7:0] CPG = 8'h52;
	logic        i_clock = 1'b0;
	logic        i_rst = 1'b1;
	logic        i_conv_valid = 1'b0;
	logic        i_calc_valid = 1'b0;
	logic        i_clear_peaks = 1'b0;
	logic        i_ecc_update = 1'b0;
	logic        i_ecc_clean = 1'b1;
	logic [7:0]  i_conv_param = 8'h00;
	logic [15:0] i_conv_value = 16'h0000;
	logic [15:0] calc [8] = '{default: 16'h0000};
	logic [15:0] lf = 16'h0044;
	logic        i_access, i_write, i_page, o_rvalid, o_invalid_cmd, o_invalid_data, o_short_loop;
	logic [7:0]  i_code, o_adc_select;
	logic [15:0] i_wdata, o_rdata;
	logic [1:0]  o_byte_count;
	logic [17:0] expq [$];
	int          failures = 0;
	int          check_count = 0;
	always #25 i_clock = ~i_clock;
	trr_host i_trr_host (.i_clock, .o_access(i_access), .o_write(i_write), .o_page(i_page),
		.o_code(i_code), .o_wdata(i_wdata));
	trr_regs i_trr_regs (.i_clock, .i_rst, .i_page, .i_access, .i_write, .i_code, .i_wdata,
		.i_conv_valid, .i_conv_param, .i_conv_value, .i_calc_valid, .i_calc_iin_ch0(calc[0]),
		.i_calc_iin_ch1(calc[1]), .i_calc_iin_total(calc[2]), .i_calc_duty_ch0(calc[3]),
		.i_calc_duty_ch1(calc[4]), .i_calc_pout_ch0(calc[5]), .i_calc_pout_ch1(calc[6]),
		.i_calc_freq(calc[7]), .i_clear_peaks, .i_ecc_update, .i_ecc_clean, .o_rdata, .o_rvalid,
		.o_byte_count, .o_invalid_cmd, .o_invalid_data, .o_adc_select, .o_short_loop);
	// Positive exponent-zero values keep float and unsigned order alike
	function automatic logic [15:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return {6'h00, lf[9:0]};
	endfunction
	task automatic check(input logic [17:0] got, input logic [17:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (failures == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic send(input logic w, p, input logic [7:0] c, input logic [15:0] d, input int g);
		@(negedge i_clock);
		repeat (g) i_trr_host.put(1'b1, 1'b0, 1'b0, 8'h00, 16'h0000);
		i_trr_host.put(1'b0, w, p, c, d);
		repeat (g + 1) @(posedge i_clock);
	endtask
	task automatic rd(input logic p, input logic [7:0] c, input logic [15:0] v, input logic [1:0] n);
		expq.push_back({n, v});
		send(1'b0, p, c, 16'h0000, 0);
	endtask
	task automatic cv(input logic [7:0] p, input logic [15:0] v);
		i_conv_valid <= 1'b1;
		i_conv_param <= p;
		i_conv_value <= v;
		@(posedge i_clock);
	endtask
	always @(posedge i_clock) begin
		if (o_rvalid === 1'b1) begin
			if (expq.size() == 0) check(18'h00000, 18'h3ffff);
			else check({o_byte_count, o_rdata}, expq.pop_front());
		end
	end
	initial begin
		#(50 * 3000);
		failures++;
		report_and_stop();
	end
	initial begin
		logic [15:0] a, b, vin;
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		rd(1'b0, 8'hd8, 16'h0000, 2'h1);
		rd(1'b0, trr_pkg::CODE_INFO, 16'h0020, 2'h2);
		i_ecc_clean <= 1'b0;
		i_ecc_update <= 1'b1;
		@(posedge i_clock);
		i_ecc_update <= 1'b0;
		rd(1'b0, trr_pkg::CODE_INFO, 16'h0000, 2'h2);
		for (int i = 0; i < 8; i++) begin
			a = rnd();
			b = rnd();
			if (i == 0) vin = b;
			cv(PRM[i], a);
			cv(PRM[i], b);
			i_conv_valid <= 1'b0;
			rd(PGS[i], RCD[i], b, 2'h2);
			rd(PGS[i], PCD[i], (a > b) ? a : b, 2'h2);
		end
		@(posedge i_clock);
		i_clear_peaks <= 1'b1;
		@(posedge i_clock);
		i_clear_peaks <= 1'b0;
		rd(1'b0, 8'hdd, 16'h0000, 2'h2);
		cv(8'h09, 16'h0123);
		i_conv_valid <= 1'b0;
		rd(1'b1, 8'hdd, 16'h0123, 2'h2);
		foreach (calc[i]) calc[i] <= rnd();
		i_calc_valid <= 1'b1;
		@(posedge i_clock);
		i_calc_valid <= 1'b0;
		for (int i = 0; i < 8; i++) rd(CPG[i], CCD[i], calc[i], 2'h2);
		send(1'b1, 1'b0, 8'hd8, 16'h000d, 2);
		rd(1'b0, 8'hd8, 16'h000d, 2'h1);
		cv(8'h05, rnd());
		cv(8'h0a, rnd());
		i_conv_valid <= 1'b0;
		rd(1'b0, 8'hda, 16'h0009, 2'h1);
		send(1'b1, 1'b0, 8'hda, 16'h0001, 0);
		rd(1'b0, 8'hda, 16'h0008, 2'h1);
		send(1'b1, 1'b0, 8'hd8, 16'h0003, 2);
		send(1'b1, 1'b0, 8'h88, 16'hffff, 0);
		rd(1'b0, 8'h88, vin, 2'h2);
		send(1'b1, 1'b0, 8'hd8, 16'h0000, 0);
		rd(1'b0, 8'h00, 16'h0000, 2'h0);
		repeat (4) @(posedge i_clock);
		check({17'h00000, expq.size() == 0}, 18'h00001);
		report_and_stop();
	end
endmodule
